// file: common/cpr_pkg.sv
// Constants and types shared by the channel current regulator files.
package cpr_pkg;

  // ----------------------------------------------------------------
  // Message layout
  // ----------------------------------------------------------------
  localparam int          MSG_RW_BIT       = 31;
  localparam int          MESSAGE_IDENTIFIER_HI        = 30;
  localparam int          MESSAGE_IDENTIFIER_LO        = 26;
  localparam int          MSG_CH_HI        = 25;
  localparam int          MSG_CH_LO        = 24;
  localparam logic [4:0]  MESSAGE_IDENTIFIER_GAIN      = 5'h05;
  localparam logic [4:0]  MESSAGE_IDENTIFIER_THRESHOLD = 5'h06;
  localparam int          PGAIN_HI         = 23;
  localparam int          PGAIN_LO         = 12;
  localparam int          IGAIN_HI         = 11;
  localparam int          IGAIN_LO         = 0;
  localparam int          THRESH_HI        = 22;
  localparam int          THRESH_LO        = 12;
  localparam int          PRELOAD_HI       = 11;
  localparam int          PRELOAD_LO       = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] GAIN_CFG_RESET   = 32'h00800800;
  localparam logic [31:0] THRESH_CFG_RESET = 32'h007ff400;

  // ----------------------------------------------------------------
  // Loop scaling
  // ----------------------------------------------------------------
  // Integrator full scale is one PWM period of PWM_PERIOD_CYCLES times 2^17.
  localparam int          CHANNELS         = 4;
  localparam logic [15:0] PWM_PERIOD_CYCLES = 16'h03e8;
  localparam int          INT_FRAC_BITS    = 17;
  localparam int          GAIN_SHIFT       = 4;
  localparam int          PRELOAD_SHIFT    = 8;
  localparam logic [33:0] INT_MAX          = 34'({18'h0, PWM_PERIOD_CYCLES} << INT_FRAC_BITS);

  typedef logic [31:0] cpr_word_type;
  typedef logic signed [11:0] cpr_err_type;

endpackage : cpr_pkg

// file: common/cpr_step_if.sv
// Carrier between the regulator top and its per-channel loop arithmetic.
`timescale 1ns/10ps
interface cpr_step_if;
  import cpr_pkg::*;
  logic        [11:0] propGain;
  logic        [11:0] intGain;
  cpr_err_type        errPrev;
  logic        [31:0] intPrev;
  logic        [31:0] intNext;
  logic        [15:0] dutyNext;

  modport calc (input propGain, input intGain, input errPrev, input intPrev,
                output intNext, output dutyNext);
  modport user (output propGain, output intGain, output errPrev, output intPrev,
                input intNext, input dutyNext);
endinterface : cpr_step_if

// file: core/cpr_pi_step.sv
// Combinational proportional-integral step for one channel.
`timescale 1ns/10ps
module cpr_pi_step
  import cpr_pkg::*;
(
  cpr_step_if.calc step
);

  logic signed [33:0] pTerm;
  logic signed [33:0] iTerm;
  logic signed [33:0] iSum;
  logic signed [33:0] iSat;
  logic signed [33:0] dSum;
  logic signed [33:0] dSat;

  // Gain times Rsense over 1.28 N in integrator units reduces to gain times error times 2^4.
  always_comb
  begin
    // Both factors are widened first so the product is formed at full width.
    pTerm = (34'(signed'({1'b0, step.propGain})) * 34'(step.errPrev)) <<< GAIN_SHIFT;
    iTerm = (34'(signed'({1'b0, step.intGain})) * 34'(step.errPrev)) <<< GAIN_SHIFT;
    iSum  = signed'({2'b00, step.intPrev}) + iTerm;
    // Clamping the integrator as well stops windup while the duty is pinned.
    if (iSum < 0)
      iSat = '0;
    else if (iSum > signed'(INT_MAX))
      iSat = signed'(INT_MAX);
    else
      iSat = iSum;
    dSum = pTerm + iSat;
    if (dSum < 0)
      dSat = '0;
    else if (dSum > signed'(INT_MAX))
      dSat = signed'(INT_MAX);
    else
      dSat = dSum;
  end

  assign step.intNext  = iSat[31:0];
  assign step.dutyNext = dSat[INT_FRAC_BITS +: 16];

endmodule : cpr_pi_step

// file: core/cpr_regulator.sv
// Four-channel PI current regulator with message-programmed gains and thresholds.
`timescale 1ns/10ps
module cpr_regulator
  import cpr_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                clkEn,
  input  wire logic                msgValid,
  input  wire cpr_word_type        msgWord,
  input  wire logic                setpointValid,
  input  wire logic [1:0]          setpointChan,
  input  wire logic [10:0]         setpointValue,
  input  wire logic [3:0][10:0]    measuredCurrent,
  input  wire logic [3:0]          regulationActive,
  input  wire logic                periodTick,
  output logic                     respValid,
  output cpr_word_type             respWord,
  output logic [3:0][15:0]         dutyCycle,
  output logic [3:0]               transientMode,
  output logic [3:0][15:0]         stepIndex
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    CPR_IDLE      = 2'b00,
    CPR_STEADY    = 2'b01,
    CPR_TRANSIENT = 2'b10
  } cpr_mode_type;

  cpr_word_type        gainCfg_q     [CHANNELS];
  cpr_word_type        threshCfg_q   [CHANNELS];
  logic [10:0]         setpoint_q    [CHANNELS];
  cpr_err_type         errPrev_q     [CHANNELS];
  logic [31:0]         integ_q       [CHANNELS];
  cpr_mode_type        mode_q        [CHANNELS];
  logic [3:0][15:0]    duty_q;
  logic [3:0][15:0]    step_q;
  logic                respValid_q;
  cpr_word_type        respWord_q;

  logic [4:0]          msgId;
  logic [1:0]          msgChan;
  logic                msgWrite;

  assign msgId    = msgWord[MESSAGE_IDENTIFIER_HI:MESSAGE_IDENTIFIER_LO];
  assign msgChan  = msgWord[MSG_CH_HI:MSG_CH_LO];
  assign msgWrite = msgWord[MSG_RW_BIT];

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [10:0] absDiff(input logic [10:0] a, input logic [10:0] b);
    absDiff = (a > b) ? (a - b) : (b - a);
  endfunction : absDiff

  function automatic logic [31:0] preloadOf(input logic [11:0] field,
                                            input logic [10:0] setpoint);
    logic [33:0] raw;
    // The product needs 23 bits; inside a concatenation it would otherwise shrink to 12.
    raw = 34'({23'(field) * 23'(setpoint), 8'h00});
    preloadOf = (raw > INT_MAX) ? INT_MAX[31:0] : raw[31:0];
  endfunction : preloadOf

  // ----------------------------------------------------------------
  // Message registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int c = 0; c < CHANNELS; c++)
      begin
        gainCfg_q[c]   <= GAIN_CFG_RESET;
        threshCfg_q[c] <= THRESH_CFG_RESET;
      end
    end
    else if (clkEn && msgValid && msgWrite)
    begin
      // Only the addressed channel's copy changes.
      if (msgId == MESSAGE_IDENTIFIER_GAIN)
        gainCfg_q[msgChan] <= {GAIN_CFG_RESET[31:24], msgWord[PGAIN_HI:IGAIN_LO]};
      if (msgId == MESSAGE_IDENTIFIER_THRESHOLD)
        threshCfg_q[msgChan] <= {THRESH_CFG_RESET[31:23], msgWord[THRESH_HI:PRELOAD_LO]};
    end
  end

  // The response echoes the stored value after any write in the same message.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      respValid_q <= 1'b0;
      respWord_q  <= '0;
    end
    else if (clkEn)
    begin
      respValid_q <= msgValid && (msgId == MESSAGE_IDENTIFIER_GAIN || msgId == MESSAGE_IDENTIFIER_THRESHOLD);
      if (msgValid && msgId == MESSAGE_IDENTIFIER_GAIN)
        respWord_q <= {msgWord[31:24],
                       msgWrite ? msgWord[PGAIN_HI:IGAIN_LO] : gainCfg_q[msgChan][23:0]};
      else if (msgValid && msgId == MESSAGE_IDENTIFIER_THRESHOLD)
        respWord_q <= {msgWord[31:24], 1'b0,
                       msgWrite ? msgWord[THRESH_HI:PRELOAD_LO] : threshCfg_q[msgChan][22:0]};
    end
  end

  // ----------------------------------------------------------------
  // Per-channel loop
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++)
    begin : gChan
      cpr_step_if  stepIf ();
      logic [10:0] thresh;
      logic [11:0] preloadField;
      cpr_err_type errNow;
      logic        setpointHit;
      logic        bigStep;

      assign thresh       = threshCfg_q[g][THRESH_HI:THRESH_LO];
      assign preloadField = threshCfg_q[g][PRELOAD_HI:PRELOAD_LO];
      assign errNow       = signed'({1'b0, setpoint_q[g]}) -
                            signed'({1'b0, measuredCurrent[g]});
      assign setpointHit  = setpointValid && (setpointChan == 2'(g));
      // Threshold and setpoint share one LSB, so they compare directly.
      assign bigStep      = absDiff(setpointValue, setpoint_q[g]) > thresh;

      assign stepIf.propGain = gainCfg_q[g][PGAIN_HI:PGAIN_LO];
      assign stepIf.intGain  = gainCfg_q[g][IGAIN_HI:IGAIN_LO];
      assign stepIf.errPrev  = errPrev_q[g];
      assign stepIf.intPrev  = integ_q[g];

      cpr_pi_step uStep
      (
        .step (stepIf.calc)
      );

      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
          setpoint_q[g] <= '0;
        else if (clkEn && setpointHit)
          setpoint_q[g] <= setpointValue;
      end

      // Mode sequencing; transient ends once the error is back inside the threshold.
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
          mode_q[g] <= CPR_IDLE;
        else if (clkEn)
        begin
          unique case (mode_q[g])
            CPR_IDLE:
              if (regulationActive[g])
                mode_q[g] <= CPR_STEADY;
            CPR_STEADY:
              if (!regulationActive[g])
                mode_q[g] <= CPR_IDLE;
              else if (setpointHit && bigStep)
                mode_q[g] <= CPR_TRANSIENT;
            CPR_TRANSIENT:
              if (!regulationActive[g])
                mode_q[g] <= CPR_IDLE;
              else if (periodTick && !setpointHit &&
                       absDiff(setpoint_q[g], measuredCurrent[g]) <= thresh)
                mode_q[g] <= CPR_STEADY;
            default:
              mode_q[g] <= CPR_IDLE;
          endcase
        end
      end

      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
          step_q[g] <= '0;
        else if (clkEn)
        begin
          // Dropping regulation clears the loop at once rather than one cycle later.
          if (mode_q[g] == CPR_IDLE || !regulationActive[g])
            step_q[g] <= '0;
          else if (periodTick)
            step_q[g] <= step_q[g] + 16'h0001;
        end
      end

      // Error is captured at each period boundary and used one period later.
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
          errPrev_q[g] <= '0;
        else if (clkEn)
        begin
          if (mode_q[g] == CPR_IDLE || !regulationActive[g])
            errPrev_q[g] <= '0;
          else if (periodTick)
            errPrev_q[g] <= errNow;
        end
      end

      // While transient the integrator holds; it is reloaded on the way back to steady.
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          integ_q[g] <= '0;
          duty_q[g]  <= '0;
        end
        else if (clkEn)
        begin
          if (mode_q[g] == CPR_IDLE || !regulationActive[g])
          begin
            integ_q[g] <= '0;
            duty_q[g]  <= '0;
          end
          else if (periodTick && mode_q[g] == CPR_STEADY)
          begin
            integ_q[g] <= stepIf.intNext;
            duty_q[g]  <= stepIf.dutyNext;
          end
          else if (periodTick && mode_q[g] == CPR_TRANSIENT)
          begin
            duty_q[g] <= (errNow > 0) ? PWM_PERIOD_CYCLES : 16'h0000;
            if (!setpointHit && absDiff(setpoint_q[g], measuredCurrent[g]) <= thresh)
              integ_q[g] <= preloadOf(preloadField, setpoint_q[g]);
          end
        end
      end

      // The transient code is the only legal one with bit 1 set, so the flop bit is the flag.
      assign transientMode[g] = mode_q[g][1];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign respValid = respValid_q;
  assign respWord  = respWord_q;
  assign dutyCycle = duty_q;
  assign stepIndex = step_q;

endmodule : cpr_regulator

// file: dv/cpr_host_model.sv
// Serial master model that hands single messages to the regulator.
`timescale 1ns/10ps
module cpr_host_model
  import cpr_pkg::*;
(
  input  wire logic   clk,
  output logic        msgValid,
  output cpr_word_type msgWord
);
  initial
  begin
    msgValid = 1'b0;
    msgWord  = 32'h0;
  end

  // Idle words carry the inverse so a stale word never looks like a fresh message.
  task automatic send(input cpr_word_type w, input int gap);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    #1;
    msgValid = 1'b1;
    msgWord  = w;
    @(posedge clk);
    #1;
    msgValid = 1'b0;
    msgWord  = ~w;
  endtask : send
endmodule : cpr_host_model

// file: dv/cpr_regulator_assertions.sv
// Port assertions for the channel current regulator.
`timescale 1ns/10ps
module cpr_regulator_assertions
  import cpr_pkg::*;
(
  input wire logic             clk,
  input wire logic             rst,
  input wire logic             clkEn,
  input wire logic             msgValid,
  input wire cpr_word_type     msgWord,
  input wire logic [3:0]       regulationActive,
  input wire logic             periodTick,
  input wire logic             respValid,
  input wire cpr_word_type     respWord,
  input wire logic [3:0][15:0] dutyCycle,
  input wire logic [3:0]       transientMode,
  input wire logic [3:0][15:0] stepIndex
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  logic hit;
  logic inRange;
  logic tick;
  assign tick = clkEn && periodTick;
  assign hit = clkEn && msgValid &&
               (msgWord[30:26] == MESSAGE_IDENTIFIER_GAIN || msgWord[30:26] == MESSAGE_IDENTIFIER_THRESHOLD);
  always_comb
  begin
    inRange = 1'b1;
    for (int c = 0; c < 4; c++)
      if (dutyCycle[c] > PWM_PERIOD_CYCLES)
        inRange = 1'b0;
  end
  chk_resp_follows: assert property (hit |=> respValid)
    else $error("no response after a gain or threshold message");
  chk_resp_only: assert property (respValid |-> $past(hit))
    else $error("response without a gain or threshold message");
  chk_resp_head: assert property (respValid |-> respWord[31:24] == $past(msgWord[31:24]))
    else $error("response header differs from request");
  chk_gain_echo: assert property (hit && msgWord[31] && msgWord[30:26] == MESSAGE_IDENTIFIER_GAIN
    |=> respWord[23:0] == $past(msgWord[23:0])) else $error("gain write not echoed");
  chk_thr_echo: assert property (hit && msgWord[31] && msgWord[30:26] == MESSAGE_IDENTIFIER_THRESHOLD
    |=> respWord[23:0] == {1'b0, $past(msgWord[22:0])}) else $error("threshold write not echoed");
  chk_duty_range: assert property (inRange)
    else $error("duty beyond one period");
  chk_idle_zero: assert property (tick && !regulationActive[0]
    |=> dutyCycle[0] == 16'h0 && stepIndex[0] == 16'h0) else $error("idle channel not zero");
  chk_step_count: assert property (tick && regulationActive[0] && stepIndex[0] != 16'h0
    |=> stepIndex[0] == $past(stepIndex[0]) + 16'h1) else $error("step index not advanced");
  chk_freeze_all: assert property (!clkEn |=> $stable(dutyCycle) && $stable(stepIndex))
    else $error("state moved while clock enable low");
  chk_bang_bang: assert property (tick && transientMode[1]
    |=> dutyCycle[1] == 16'h0 || dutyCycle[1] == PWM_PERIOD_CYCLES) else $error("transient duty");
endmodule : cpr_regulator_assertions

bind cpr_regulator cpr_regulator_assertions cpr_regulator_assertions_inst (.clk, .rst, .clkEn,
  .msgValid, .msgWord, .regulationActive, .periodTick, .respValid, .respWord, .dutyCycle,
  .transientMode, .stepIndex);

// file: dv/cpr_regulator_bench.sv
// Self-checking bench for the channel current regulator.
`timescale 1ns/10ps
module cpr_regulator_bench
  import cpr_pkg::*;
;
  localparam longint FULL = longint'(INT_MAX);
  logic clk = 1'b0, rst = 1'b1, clkEn = 1'b1, setpointValid = 1'b0, periodTick = 1'b0;
  logic [1:0] setpointChan = 2'h0;
  logic [10:0] setpointValue = 11'h0;
  logic [3:0][10:0] measuredCurrent = '0;
  logic [3:0] regulationActive = 4'h0;
  logic msgValid, respValid;
  cpr_word_type msgWord, respWord;
  logic [3:0][15:0] dutyCycle, stepIndex;
  logic [3:0] transientMode;
  logic [31:0] gainReg[4], thrReg[4];
  int errors = 0, compares = 0;
  longint integ, errPrev, p, i, d, sp;

  always #5 clk = ~clk;

  cpr_regulator cpr_regulator_inst (.clk, .rst, .clkEn, .msgValid, .msgWord, .setpointValid,
    .setpointChan, .setpointValue, .measuredCurrent, .regulationActive, .periodTick,
    .respValid, .respWord, .dutyCycle, .transientMode, .stepIndex);
  cpr_host_model cpr_host_model_inst (.clk, .msgValid, .msgWord);

  function automatic longint clampv(input longint v);
    return v < 0 ? 0 : (v > FULL ? FULL : v);
  endfunction : clampv

  task automatic check_word(input string what, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, e, g);
    end
  endtask : check_word

  task automatic check_num(input string what, input logic [15:0] e, input logic [15:0] g);
    check_word(what, {16'h0, e}, {16'h0, g});
  endtask : check_num

  task automatic tally_and_finish;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic msg(input cpr_word_type w);
    logic [1:0] c;
    logic hit;
    c = w[25:24];
    hit = clkEn && (w[30:26] == MESSAGE_IDENTIFIER_GAIN || w[30:26] == MESSAGE_IDENTIFIER_THRESHOLD);
    if (hit && w[31] && w[30:26] == MESSAGE_IDENTIFIER_GAIN)
      gainReg[c] = {8'h0, w[23:0]};
    if (hit && w[31] && w[30:26] == MESSAGE_IDENTIFIER_THRESHOLD)
      thrReg[c] = {9'h0, w[22:0]};
    cpr_host_model_inst.send(w, $urandom_range(2));
    check_num("respValid", {15'h0, hit}, {15'h0, respValid});
    if (hit)
      check_word("respWord", {w[31:24], w[27] ? thrReg[c][23:0] : gainReg[c][23:0]}, respWord);
  endtask : msg

  task automatic pulse(input logic sel, input logic [1:0] c, input logic [10:0] v);
    @(posedge clk);
    #1;
    {setpointValid, periodTick, setpointChan, setpointValue} = {sel, !sel, c, v};
    @(posedge clk);
    #1;
    {setpointValid, periodTick, setpointValue} = {2'b00, ~v};
  endtask : pulse

  task automatic trans(input logic [11:0] pre, input logic [10:0] v);
    msg({1'b1, MESSAGE_IDENTIFIER_THRESHOLD, 2'h1, 1'b0, 11'd10, pre});
    measuredCurrent[1] = 11'h0;
    pulse(1'b1, 2'h1, v);
    check_num("mode1", 16'h1, {15'h0, transientMode[1]});
    pulse(1'b0, 2'h0, 11'h0);
    check_num("duty1", PWM_PERIOD_CYCLES, dutyCycle[1]);
    measuredCurrent[1] = v;
    pulse(1'b0, 2'h0, 11'h0);
    @(posedge clk);
    #1;
    check_num("mode1", 16'h0, {15'h0, transientMode[1]});
    pulse(1'b0, 2'h0, 11'h0);
    d = clampv(longint'(pre) * v * 256) >> INT_FRAC_BITS;
    check_num("duty1", 16'(d), dutyCycle[1]);
  endtask : trans

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(62641));
    for (int c = 0; c < 4; c++)
      {gainReg[c], thrReg[c]} = {GAIN_CFG_RESET, THRESH_CFG_RESET};
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    for (int c = 0; c < 12; c++)
      msg({1'b0, c[2] ? MESSAGE_IDENTIFIER_THRESHOLD : MESSAGE_IDENTIFIER_GAIN, 2'(c), 24'h0});
    repeat (8)
      msg({1'b1, $urandom_range(1) ? MESSAGE_IDENTIFIER_GAIN : MESSAGE_IDENTIFIER_THRESHOLD, 26'($urandom)});
    for (int c = 0; c < 8; c++)
      msg({c[0], c[1] ? MESSAGE_IDENTIFIER_THRESHOLD : MESSAGE_IDENTIFIER_GAIN, c[3:2], 24'h0});
    foreach (gainReg[c])
      msg({1'b1, 5'(c * 7 + 3), 26'($urandom)});
    @(posedge clk);
    #1 clkEn = 1'b0;
    msg({1'b1, MESSAGE_IDENTIFIER_GAIN, 26'($urandom)});
    clkEn = 1'b1;
    msg({1'b1, MESSAGE_IDENTIFIER_GAIN, 2'h0, 12'($urandom_range(255)), 12'($urandom)});
    {p, i} = {64'(gainReg[0][23:12]), 64'(gainReg[0][11:0])};
    pulse(1'b0, 2'h0, 11'h0);
    sp = $urandom_range(2047);
    pulse(1'b1, 2'h0, 11'(sp));
    regulationActive = 4'h3;
    {integ, errPrev} = '0;
    for (int k = 1; k < 13; k++)
    begin
      measuredCurrent[0] = 11'($urandom);
      pulse(1'b0, 2'h0, 11'h0);
      integ = clampv(integ + i * errPrev * 16);
      d = clampv(p * errPrev * 16 + integ) >> INT_FRAC_BITS;
      errPrev = sp - longint'(measuredCurrent[0]);
      check_num("duty0", 16'(d), dutyCycle[0]);
      check_num("step0", 16'(k), stepIndex[0]);
    end
    regulationActive[0] = 1'b0;
    pulse(1'b0, 2'h0, 11'h0);
    check_num("duty0", 16'h0, dutyCycle[0]);
    msg({1'b1, MESSAGE_IDENTIFIER_THRESHOLD, 2'h1, 1'b0, 11'd10, 12'h0});
    pulse(1'b1, 2'h1, 11'd10);
    check_num("mode1", 16'h0, {15'h0, transientMode[1]});
    trans(12'h800, 11'd100);
    trans(12'hfff, 11'd2000);
    tally_and_finish();
  end

  // The whole sequence needs well under two thousand cycles; this span leaves ample margin.
  initial
  begin
    #200000;
    errors++;
    tally_and_finish();
  end
endmodule : cpr_regulator_bench
